// ---- rtl/fpr_pkg.sv ----
// constants and helpers shared by the fan ramp and floor block
package fpr_pkg;

    // ----------------------------------------------------------------
    // bus and register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 8;
    localparam int          NUM_PWM     = 3;
    localparam logic [7:0]  OFS_CTRL    = 8'h62;
    localparam logic [7:0]  OFS_PWM1_FLOOR_SELECT    = 8'h64;
    localparam logic [7:0]  OFS_PWM2_FLOOR_SELECT    = 8'h65;
    localparam logic [7:0]  OFS_PWM3_FLOOR_SELECT    = 8'h66;
    localparam logic [7:0]  OFS_DUTY1   = 8'h67;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [7:0]  MIN_RESET   = 8'h00;
    localparam logic [7:0]  READ_ZERO   = 8'h00;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int RATE_LSB    = 0;
    localparam int RATE_MSB    = 2;
    localparam int EN_BIT      = 3;
    localparam int SYNC_BIT    = 4;
    localparam int FLOOR_LSB   = 5;

    localparam logic [7:0] DUTY_OFF  = 8'h00;
    localparam logic [7:0] DUTY_FULL = 8'hFF;

    // ----------------------------------------------------------------
    // ramp timing: one step per slot at slowest rate spans 33% to 100%
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned RAMP_SLOW_MS  = 35000;
    localparam int unsigned RAMP_FAST_MS  = 800;
    localparam int unsigned RAMP_SPAN     = 170;
    localparam int unsigned SLOT_MS       = RAMP_SLOW_MS / RAMP_SPAN;
    localparam int unsigned SLOT_CYC      = SLOT_MS * 1000000 / CLK_PERIOD_NS;

    localparam logic [2:0] RATE_C0 = 3'h0;
    localparam logic [2:0] RATE_C1 = 3'h1;
    localparam logic [2:0] RATE_C2 = 3'h2;
    localparam logic [2:0] RATE_C3 = 3'h3;
    localparam logic [2:0] RATE_C4 = 3'h4;
    localparam logic [2:0] RATE_C5 = 3'h5;
    localparam logic [2:0] RATE_C6 = 3'h6;

    function automatic logic [7:0] fpr_step_size(input logic [2:0] rate);
        case (rate)
            RATE_C0: fpr_step_size = 8'h01;
            RATE_C1: fpr_step_size = 8'h02;
            RATE_C2: fpr_step_size = 8'h03;
            RATE_C3: fpr_step_size = 8'h05;
            RATE_C4: fpr_step_size = 8'h08;
            RATE_C5: fpr_step_size = 8'h0C;
            RATE_C6: fpr_step_size = 8'h18;
            default: fpr_step_size = 8'h30;
        endcase
    endfunction : fpr_step_size

endpackage : fpr_pkg

// ---- rtl/fpr_ramp.sv ----
// duty stepper that walks an applied duty toward its target
`timescale 1ns/10ps
module fpr_ramp
    import fpr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // control
    input  wire logic        enable_i,
    input  wire logic        slot_i,
    input  wire logic [7:0]  step_i,
    input  wire logic [7:0]  target_i,
    // result
    output logic      [7:0]  duty_o
);
    import fpr_pkg::*;

    logic [7:0] duty_q;
    logic [7:0] duty_d;
    logic [7:0] gap;

    always_comb begin
        duty_d = duty_q;
        gap    = 8'h00;
        if (!enable_i) begin
            duty_d = target_i;
        end else if (slot_i) begin
            if (target_i > duty_q) begin
                gap    = target_i - duty_q;
                duty_d = (gap > step_i) ? duty_q + step_i : target_i;
            end else if (target_i < duty_q) begin
                gap    = duty_q - target_i;
                duty_d = (gap > step_i) ? duty_q - step_i : target_i;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            duty_q <= DUTY_OFF;
        end else begin
            duty_q <= duty_d;
        end
    end

    assign duty_o = duty_q;

    a_direct_load: assert property (@(posedge clk_i) disable iff (rst_i)
        !enable_i |=> duty_q == $past(target_i))
        else $error("duty not loaded directly with ramp off");

    a_hold_between: assert property (@(posedge clk_i) disable iff (rst_i)
        enable_i && !slot_i |=> $stable(duty_q))
        else $error("duty moved outside a slot");

    a_step_size_up: assert property (@(posedge clk_i) disable iff (rst_i)
        enable_i && slot_i && (target_i > duty_q) && (target_i - duty_q > step_i)
        |=> duty_q == $past(duty_q) + $past(step_i))
        else $error("upward step differs from rate increment");

    a_step_size_down: assert property (@(posedge clk_i) disable iff (rst_i)
        enable_i && slot_i && (duty_q > target_i) && (duty_q - target_i > step_i)
        |=> duty_q == $past(duty_q) - $past(step_i))
        else $error("downward step differs from rate increment");

endmodule : fpr_ramp

// ---- rtl/fpr_top.sv ----
// fan pwm ramp, tach sync and low-temperature floor control
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/10ps

// What this block does
// - ramp enabled: pwm1 duty steps toward target
// - rate code picks step 1,2,3,5,8,12,24,48
// - slot length gives 35 s slowest ramp
// - ramp acts only while bit 3 set
// - sync set: tach 2,3,4 follow pwm3
// - sync clear: only tach 3,4 follow
// - pwm1 below threshold: zero or minimum per bit5
// - pwm2 below threshold: zero or minimum per bit6
// - pwm3 below threshold: zero or minimum per bit7
module fpr_top
    import fpr_pkg::*;
#(
    parameter int unsigned SLOT_CYCLES = SLOT_CYC
)(
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // register port
    input  wire logic [ADDR_W-1:0]    addr_i,
    input  wire logic [DATA_W-1:0]    wdata_i,
    input  wire logic                 we_i,
    input  wire logic                 re_i,
    output logic      [DATA_W-1:0]    rdata_o,
    // fan control loop
    input  wire logic [NUM_PWM-1:0]   auto_mode_i,
    input  wire logic [NUM_PWM-1:0]   below_floor_i,
    input  wire logic [7:0]           calc_duty1_i,
    input  wire logic [7:0]           calc_duty2_i,
    input  wire logic [7:0]           calc_duty3_i,
    // fan side
    output logic      [7:0]           duty1_o,
    output logic      [7:0]           duty2_o,
    output logic      [7:0]           duty3_o,
    output logic      [NUM_PWM-1:0]   pwm_o,
    output logic      [NUM_PWM-1:0]   tach_sync_o
);
    import fpr_pkg::*;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0]          ctrl_q,  ctrl_d;
    logic [7:0]          min_q  [NUM_PWM];
    logic [7:0]          min_d  [NUM_PWM];
    logic [7:0]          rdata_q, rdata_d;
    logic [31:0]         slot_cnt_q, slot_cnt_d;
    logic                slot_q,  slot_d;
    logic [7:0]          pwm_cnt_q, pwm_cnt_d;
    logic [NUM_PWM-1:0]  pwm_q,   pwm_d;
    logic [NUM_PWM-1:0]  sync_q,  sync_d;
    logic [7:0]          duty2_q, duty2_d;
    logic [7:0]          duty3_q, duty3_d;
    logic [7:0]          calc_w   [NUM_PWM];
    logic [7:0]          target_w [NUM_PWM];
    logic [7:0]          duty1_w;
    logic [7:0]          duty_all [NUM_PWM];

    assign calc_w[0] = calc_duty1_i;
    assign calc_w[1] = calc_duty2_i;
    assign calc_w[2] = calc_duty3_i;

    // ----------------------------------------------------------------
    // floor selection below start threshold minus hysteresis
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_PWM; i++) begin : g_floor
        always_comb begin
            target_w[i] = calc_w[i];
            if (auto_mode_i[i] && below_floor_i[i]) begin
                target_w[i] = ctrl_q[FLOOR_LSB+i] ? min_q[i] : DUTY_OFF;
            end
        end
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_d  = ctrl_q;
        min_d   = min_q;
        rdata_d = READ_ZERO;
        if (we_i) begin
            if (addr_i == OFS_CTRL) begin
                ctrl_d = wdata_i;
            end else if (addr_i == OFS_PWM1_FLOOR_SELECT) begin
                min_d[0] = wdata_i;
            end else if (addr_i == OFS_PWM2_FLOOR_SELECT) begin
                min_d[1] = wdata_i;
            end else if (addr_i == OFS_PWM3_FLOOR_SELECT) begin
                min_d[2] = wdata_i;
            end
        end
        if (re_i) begin
            if (addr_i == OFS_CTRL) begin
                rdata_d = ctrl_q;
            end else if (addr_i == OFS_PWM1_FLOOR_SELECT) begin
                rdata_d = min_q[0];
            end else if (addr_i == OFS_PWM2_FLOOR_SELECT) begin
                rdata_d = min_q[1];
            end else if (addr_i == OFS_PWM3_FLOOR_SELECT) begin
                rdata_d = min_q[2];
            end else if (addr_i == OFS_DUTY1) begin
                rdata_d = duty1_w;
            end
        end
    end

    // ----------------------------------------------------------------
    // slot timer, pwm waveform and tach sync
    // ----------------------------------------------------------------
    always_comb begin
        slot_cnt_d = slot_cnt_q + 32'h1;
        slot_d     = 1'b0;
        if (slot_cnt_q >= SLOT_CYCLES - 1) begin
            slot_cnt_d = 32'h0;
            slot_d     = 1'b1;
        end
        pwm_cnt_d = pwm_cnt_q + 8'h01;
        for (int k = 0; k < NUM_PWM; k++) begin
            // full duty keeps the pin high; the compare alone would drive it low while the counter is at FF
            pwm_d[k] = (duty_all[k] == DUTY_FULL) || (pwm_cnt_q < duty_all[k]);
        end
        sync_d    = {1'b1, 1'b1, ctrl_q[SYNC_BIT]};
        duty2_d   = target_w[1];
        duty3_d   = target_w[2];
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q     <= CTRL_RESET;
            min_q      <= '{default: MIN_RESET};
            rdata_q    <= READ_ZERO;
            slot_cnt_q <= 32'h0;
            slot_q     <= 1'b0;
            pwm_cnt_q  <= 8'h00;
            pwm_q      <= '0;
            sync_q     <= '0;
            duty2_q    <= DUTY_OFF;
            duty3_q    <= DUTY_OFF;
        end else begin
            ctrl_q     <= ctrl_d;
            min_q      <= min_d;
            rdata_q    <= rdata_d;
            slot_cnt_q <= slot_cnt_d;
            slot_q     <= slot_d;
            pwm_cnt_q  <= pwm_cnt_d;
            pwm_q      <= pwm_d;
            sync_q     <= sync_d;
            duty2_q    <= duty2_d;
            duty3_q    <= duty3_d;
        end
    end

    // ----------------------------------------------------------------
    // pwm1 ramp; outputs 2 and 3 load directly here
    // ----------------------------------------------------------------
    fpr_ramp u_ramp1 (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .enable_i (ctrl_q[EN_BIT]),
        .slot_i   (slot_q),
        .step_i   (fpr_step_size(ctrl_q[RATE_MSB:RATE_LSB])),
        .target_i (target_w[0]),
        .duty_o   (duty1_w)
    );

    assign duty_all[0] = duty1_w;
    assign duty_all[1] = duty2_q;
    assign duty_all[2] = duty3_q;
    assign duty1_o     = duty1_w;
    assign duty2_o     = duty2_q;
    assign duty3_o     = duty3_q;
    assign pwm_o       = pwm_q;
    assign tach_sync_o = sync_q;
    assign rdata_o     = rdata_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_fan_speed_in_2_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_q[SYNC_BIT] |=> tach_sync_o[0])
        else $error("tach 2 not synced with sync bit set");

    a_fan_speed_in_2_free: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_q[SYNC_BIT] |=> !tach_sync_o[0])
        else $error("tach sync wrong with sync bit clear");

    // the first edge after release still sees the reset value, so wait one edge
    a_tach34_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> tach_sync_o[2:1] == 2'b11)
        else $error("tach 3 and 4 not synced");

    a_pwm2_floor: assert property (@(posedge clk_i) disable iff (rst_i)
        auto_mode_i[1] && below_floor_i[1]
        |=> duty2_o == ($past(ctrl_q[FLOOR_LSB+1]) ? $past(min_q[1]) : DUTY_OFF))
        else $error("pwm2 floor duty wrong");

    a_pwm3_floor: assert property (@(posedge clk_i) disable iff (rst_i)
        auto_mode_i[2] && below_floor_i[2]
        |=> duty3_o == ($past(ctrl_q[FLOOR_LSB+2]) ? $past(min_q[2]) : DUTY_OFF))
        else $error("pwm3 floor duty wrong");

    a_pwm1_floor: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_q[EN_BIT] && auto_mode_i[0] && below_floor_i[0] && !ctrl_q[FLOOR_LSB]
        |=> duty1_o == DUTY_OFF)
        else $error("pwm1 not off below threshold");

    a_ctrl_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        re_i && addr_i == OFS_CTRL |=> rdata_o == $past(ctrl_q))
        else $error("control readback mismatch");

    a_pwm1_min: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_q[EN_BIT] && auto_mode_i[0] && below_floor_i[0] && ctrl_q[FLOOR_LSB]
        |=> duty1_o == $past(min_q[0]))
        else $error("pwm1 not at minimum below threshold");

    a_rdata_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !re_i |=> rdata_o == READ_ZERO)
        else $error("read data stand without a read");

    a_slot_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
        slot_q |-> slot_cnt_q == 32'h0)
        else $error("slot pulse off its period");

endmodule : fpr_top

// ---- sim/fpr_fan_model.sv ----
// behavioural fan: measures how long its pwm drive is high over a 256-cycle window
`timescale 1ns/10ps
module fpr_fan_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // drive from the block
    input  wire logic       pwm_i,
    // measured on-time of the last window
    output logic      [8:0] high_cnt_o
);
    logic [7:0] win_q;
    logic [8:0] acc_q;

    // a 256-cycle window spans one full pwm period, so its phase does not matter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            win_q      <= 8'h00;
            acc_q      <= 9'h000;
            high_cnt_o <= 9'h000;
        end else begin
            win_q <= win_q + 8'h01;
            if (win_q == 8'hFF) begin
                high_cnt_o <= acc_q + {8'h00, pwm_i};
                acc_q      <= 9'h000;
            end else begin
                acc_q <= acc_q + {8'h00, pwm_i};
            end
        end
    end
endmodule : fpr_fan_model

// ---- sim/test_fpr_top.sv ----
// self-checking bench for the fan ramp and floor block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin num_errors++; \
    $display("mismatch %s exp %h got %h", nm, ex, got); end end
module test_fpr_top;
    import fpr_pkg::*;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic       we_i = 1'b0;
    logic       re_i = 1'b0;
    logic [7:0] rdata_o;
    logic [2:0] auto_mode_i = 3'h0;
    logic [2:0] below_floor_i = 3'h0;
    logic [7:0] calc_duty1_i = 8'h00;
    logic [7:0] calc_duty2_i = 8'h00;
    logic [7:0] calc_duty3_i = 8'h00;
    logic [7:0] duty1_o;
    logic [7:0] duty2_o;
    logic [7:0] duty3_o;
    logic [2:0] pwm_o;
    logic [2:0] tach_sync_o;
    logic [8:0] fan_cnt;
    logic [8:0] fan1_cnt;
    logic [8:0] fan3_cnt;
    localparam int SIM_SLOT = 8;
    int         gap_n = 0;
    logic [7:0] v;
    logic [8:0] e;
    logic [7:0] steps [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};
    int         num_errors = 0;
    int         tests_run = 0;
    int         cyc = 0;

    always #4 clk_i = ~clk_i;

    fpr_top #(.SLOT_CYCLES(SIM_SLOT)) i_fpr_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
        .auto_mode_i(auto_mode_i), .below_floor_i(below_floor_i),
        .calc_duty1_i(calc_duty1_i), .calc_duty2_i(calc_duty2_i),
        .calc_duty3_i(calc_duty3_i), .duty1_o(duty1_o), .duty2_o(duty2_o),
        .duty3_o(duty3_o), .pwm_o(pwm_o), .tach_sync_o(tach_sync_o));

    fpr_fan_model i_fpr_fan_model (.clk_i(clk_i), .rst_i(rst_i), .pwm_i(pwm_o[1]),
        .high_cnt_o(fan_cnt));
    fpr_fan_model i_fpr_fan_model_1 (.clk_i(clk_i), .rst_i(rst_i), .pwm_i(pwm_o[0]),
        .high_cnt_o(fan1_cnt));
    fpr_fan_model i_fpr_fan_model_3 (.clk_i(clk_i), .rst_i(rst_i), .pwm_i(pwm_o[2]),
        .high_cnt_o(fan3_cnt));

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        we_i    <= 1'b1;
        @(posedge clk_i);
        we_i    <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        re_i   <= 1'b1;
        @(posedge clk_i);
        re_i   <= 1'b0;
        #1;
        v = rdata_o;
    endtask : rd

    // bounded wait for the ramp to take its next step
    task automatic wait_chg(input logic [7:0] old);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (duty1_o === old && n < 40);
        gap_n = n;
    endtask : wait_chg

    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 8'h62; a <= 8'h66; a++) begin
            rd(a[7:0]);
            `CHK("reg reset", 8'h00, v)
        end
        wr(8'h70, 8'hFF);
        rd(8'h70);
        `CHK("unmapped", 8'h00, v)
        @(posedge clk_i);
        calc_duty1_i <= 8'h80;
        settle();
        `CHK("direct duty1", 8'h80, duty1_o)
        rd(OFS_DUTY1);
        `CHK("duty1 reg", 8'h80, v)
        @(posedge clk_i);
        #1;
        `CHK("rdata one cycle", 8'h00, rdata_o)
        for (int c = 0; c < 8; c++) begin
            wr(OFS_CTRL, 8'h00);
            calc_duty1_i <= 8'h00;
            settle();
            wr(OFS_CTRL, 8'h08 | c[7:0]);
            calc_duty1_i <= 8'hFF;
            wait_chg(8'h00);
            `CHK("first step", steps[c], duty1_o)
            e = {steps[c], 1'b0};
            wait_chg(duty1_o);
            `CHK("second step", (e > 9'h0FF) ? 8'hFF : e[7:0], duty1_o)
            `CHK("slot gap", SIM_SLOT, gap_n)
        end
        @(posedge clk_i);
        calc_duty1_i <= 8'h00;
        wait_chg(duty1_o);
        `CHK("down step", 8'h30, duty1_o)
        wr(OFS_PWM1_FLOOR_SELECT, 8'h20);
        wr(OFS_PWM2_FLOOR_SELECT, 8'h30);
        wr(OFS_PWM3_FLOOR_SELECT, 8'h40);
        wr(OFS_CTRL, 8'h00);
        calc_duty1_i  <= 8'h90;
        calc_duty2_i  <= 8'h90;
        calc_duty3_i  <= 8'h90;
        auto_mode_i   <= 3'h7;
        below_floor_i <= 3'h7;
        settle();
        `CHK("pwm1 off", 8'h00, duty1_o)
        `CHK("pwm2 off", 8'h00, duty2_o)
        `CHK("pwm3 off", 8'h00, duty3_o)
        wr(OFS_CTRL, 8'hE0);
        settle();
        `CHK("pwm1 min", 8'h20, duty1_o)
        `CHK("pwm2 min", 8'h30, duty2_o)
        `CHK("pwm3 min", 8'h40, duty3_o)
        rd(OFS_CTRL);
        `CHK("ctrl readback", 8'hE0, v)
        rd(OFS_PWM3_FLOOR_SELECT);
        `CHK("pwm3_floor_select readback", 8'h40, v)
        wr(OFS_CTRL, 8'h10);
        settle();
        `CHK("sync all", 3'h7, tach_sync_o)
        wr(OFS_CTRL, 8'h00);
        settle();
        `CHK("sync two", 3'h6, tach_sync_o)
        @(posedge clk_i);
        auto_mode_i  <= 3'h0;
        calc_duty2_i <= 8'h40;
        calc_duty3_i <= 8'hFF;
        repeat (600) @(posedge clk_i);
        #1;
        `CHK("fan on-time", 9'h040, fan_cnt)
        `CHK("fan1 on-time", 9'h090, fan1_cnt)
        `CHK("fan3 full on", 9'h100, fan3_cnt)
        conclude();
    end
endmodule : test_fpr_top
